// ### shared/pif_pkg.sv
// constants for the peripheral interrupt enable and flag block
package pif_pkg;
  localparam int          PIF_ADR_W         = 8;
  localparam int          PIF_DAT_W         = 32;
  // register indices; byte address is four times the index
  localparam logic [5:0]  PIF_IDX_ENABLE_TWO  = 6'h11;
  localparam logic [5:0]  PIF_IDX_REQUEST_ONE = 6'h16;
  localparam logic [5:0]  PIF_IDX_MODE        = 6'h20;
  localparam logic [5:0]  PIF_IDX_PERIOD_ONE  = 6'h21;
  localparam logic [5:0]  PIF_IDX_PERIOD_THREE = 6'h22;
  // enable register fields
  localparam int          PIF_EN_SERIAL     = 7;
  localparam int          PIF_EN_COLLISION  = 6;
  localparam int          PIF_EN_CONVERTER  = 5;
  localparam int          PIF_EN_UNUSED     = 4;
  localparam int          PIF_EN_CAPTURE4   = 3;
  localparam int          PIF_EN_CAPTURE3   = 2;
  localparam int          PIF_EN_UART2_TX   = 1;
  localparam int          PIF_EN_UART2_RX   = 0;
  localparam logic [7:0]  PIF_EN_WMASK      = 8'hEF;
  localparam logic [7:0]  PIF_EN_RESET      = 8'h00;
  // request register fields
  localparam int          PIF_FL_PORT_B     = 7;
  localparam int          PIF_FL_TIMER3     = 6;
  localparam int          PIF_FL_TIMER2     = 5;
  localparam int          PIF_FL_TIMER1     = 4;
  localparam int          PIF_FL_CAPTURE2   = 3;
  localparam int          PIF_FL_CAPTURE1   = 2;
  localparam int          PIF_FL_UART1_TX   = 1;
  localparam int          PIF_FL_UART1_RX   = 0;
  localparam logic [7:0]  PIF_FL_WMASK      = 8'hFC;
  localparam logic [7:0]  PIF_FL_RESET      = 8'h00;
  // mode register fields
  localparam int          PIF_MD_CAPTURE1   = 0;
  localparam int          PIF_MD_WIDE       = 1;
  localparam logic [1:0]  PIF_MD_RESET      = 2'h0;
  localparam logic [15:0] PIF_PERIOD_RESET  = 16'hFFFF;
  localparam int          PIF_PORT_B_W      = 4;
endpackage

// ### core/pif_roll_det.sv
// detects a counter rolling over to zero from a limit value
`timescale 1ns/1ps
module pif_roll_det #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] count_i,
  input  wire logic [W-1:0] limit_i,
  output logic              roll_o
);
  logic [W-1:0] prev_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prev_reg <= '0;
    else
      prev_reg <= count_i;
  end

  // previous value equalled a nonzero limit and counter now reads zero
  assign roll_o = (prev_reg == limit_i) && (count_i == '0) && (prev_reg != '0);
endmodule // pif_roll_det

// ### core/pif_core.sv
// enable register two, request register one and their wishbone slave
`timescale 1ns/1ps
module pif_core
  import pif_pkg::*;
(
  input  wire logic                             clk_i,
  input  wire logic                             rst_i,
  input  wire logic                             wb_cyc_i,
  input  wire logic                             wb_stb_i,
  input  wire logic                             wb_we_i,
  input  wire logic [pif_pkg::PIF_ADR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]                       wb_sel_i,
  input  wire logic [pif_pkg::PIF_DAT_W-1:0]    wb_dat_i,
  output logic      [pif_pkg::PIF_DAT_W-1:0]    wb_dat_o,
  output logic                                  wb_ack_o,
  input  wire logic [pif_pkg::PIF_PORT_B_W-1:0] port_b_pins_i,
  input  wire logic                             capture_one_event_i,
  input  wire logic                             capture_two_event_i,
  input  wire logic [7:0]                       timer_one_count_i,
  input  wire logic [7:0]                       timer_two_count_i,
  input  wire logic [15:0]                      timer_three_count_i,
  input  wire logic                             uart_one_tx_empty_i,
  input  wire logic                             uart_one_rx_full_i,
  input  wire logic                             global_irq_disable_i,
  input  wire logic [7:0]                       second_flags_i,
  output logic      [7:0]                       peripheral_request_one_o,
  output logic      [7:0]                       peripheral_enable_two_o,
  output logic      [7:0]                       second_irq_req_o,
  output logic                                  peripheral_irq_o
);
  import pif_pkg::*;

  logic [7:0]              peripheral_enable_two_reg;
  logic [7:0]              peripheral_request_one_reg;
  logic [1:0]              mode_reg;
  logic [7:0]              timer_one_period_reg;
  logic [7:0]              timer_two_period_reg;
  logic [15:0]             timer_three_period_reg;
  logic                    ack_reg;
  logic [PIF_DAT_W-1:0]    dat_reg;
  logic [7:0]              second_req_reg;
  logic                    irq_reg;
  logic [PIF_PORT_B_W-1:0] port_b_meta_reg;
  logic [PIF_PORT_B_W-1:0] port_b_sync_reg;
  logic [PIF_PORT_B_W-1:0] port_b_latch_reg;
  logic [7:0]              flag_set;
  logic [7:0]              request_next;
  logic                    req;
  logic                    wr_take;
  logic                    rd_take;
  logic [5:0]              idx;
  logic                    port_b_mismatch;
  logic                    capture_one_mode;
  logic                    wide_mode;
  logic                    timer_one_roll;
  logic                    timer_two_roll;
  logic                    timer_three_roll;
  logic [15:0]             timer_one_count;
  logic [15:0]             timer_one_limit;
  logic [15:0]             timer_three_limit;

  assign idx              = wb_adr_i[7:2];
  assign req              = wb_cyc_i && wb_stb_i;
  assign wr_take          = req && wb_we_i && ack_reg;
  assign rd_take          = req && !wb_we_i && ack_reg;
  assign capture_one_mode = mode_reg[PIF_MD_CAPTURE1];
  assign wide_mode        = mode_reg[PIF_MD_WIDE];

  // wishbone answer one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= req && !ack_reg;
  end

  // read data captured with the answer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_reg <= '0;
    else if (req && !ack_reg)
    begin
      if (idx == PIF_IDX_ENABLE_TWO)
        dat_reg <= {24'h000000, peripheral_enable_two_reg & PIF_EN_WMASK};
      else if (idx == PIF_IDX_REQUEST_ONE)
        dat_reg <= {24'h000000, peripheral_request_one_reg};
      else if (idx == PIF_IDX_MODE)
        dat_reg <= {30'h00000000, mode_reg};
      else if (idx == PIF_IDX_PERIOD_ONE)
        dat_reg <= {16'h0000, timer_two_period_reg, timer_one_period_reg};
      else if (idx == PIF_IDX_PERIOD_THREE)
        dat_reg <= {16'h0000, timer_three_period_reg};
      else
        dat_reg <= '0;
    end
  end

  // enable register two
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      peripheral_enable_two_reg <= PIF_EN_RESET;
    else if (wr_take && idx == PIF_IDX_ENABLE_TWO && wb_sel_i[0])
      peripheral_enable_two_reg <= wb_dat_i[7:0] & PIF_EN_WMASK;
  end

  // mode and period registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_reg               <= PIF_MD_RESET;
      timer_one_period_reg   <= PIF_PERIOD_RESET[7:0];
      timer_two_period_reg   <= PIF_PERIOD_RESET[7:0];
      timer_three_period_reg <= PIF_PERIOD_RESET;
    end
    else if (wr_take)
    begin
      if (idx == PIF_IDX_MODE && wb_sel_i[0])
        mode_reg <= wb_dat_i[1:0];
      else if (idx == PIF_IDX_PERIOD_ONE)
      begin
        if (wb_sel_i[0])
          timer_one_period_reg <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          timer_two_period_reg <= wb_dat_i[15:8];
      end
      else if (idx == PIF_IDX_PERIOD_THREE)
      begin
        if (wb_sel_i[0])
          timer_three_period_reg[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          timer_three_period_reg[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // port b pins synchronised, latched on each read of the request register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_b_meta_reg <= '0;
      port_b_sync_reg <= '0;
    end
    else
    begin
      port_b_meta_reg <= port_b_pins_i;
      port_b_sync_reg <= port_b_meta_reg;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port_b_latch_reg <= '0;
    else if (rd_take && idx == PIF_IDX_REQUEST_ONE)
      port_b_latch_reg <= port_b_sync_reg;
  end

  assign port_b_mismatch = (port_b_sync_reg != port_b_latch_reg);

  // timer rollover detection
  assign timer_one_count   = wide_mode ? {timer_two_count_i, timer_one_count_i} : {8'h00, timer_one_count_i};
  assign timer_one_limit   = wide_mode ? {timer_two_period_reg, timer_one_period_reg} : {8'h00, timer_one_period_reg};
  assign timer_three_limit = capture_one_mode ? 16'hFFFF : timer_three_period_reg;

  pif_roll_det #(.W(16)) timer_one_det (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .count_i (timer_one_count),
    .limit_i (timer_one_limit),
    .roll_o  (timer_one_roll)
  );

  pif_roll_det #(.W(8)) timer_two_det (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .count_i (timer_two_count_i),
    .limit_i (timer_two_period_reg),
    .roll_o  (timer_two_roll)
  );

  pif_roll_det #(.W(16)) timer_three_det (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .count_i (timer_three_count_i),
    .limit_i (timer_three_limit),
    .roll_o  (timer_three_roll)
  );

  // hardware set terms, independent of any enable
  always_comb
  begin
    flag_set                  = 8'h00;
    flag_set[PIF_FL_PORT_B]   = port_b_mismatch;
    flag_set[PIF_FL_TIMER3]   = timer_three_roll;
    flag_set[PIF_FL_TIMER2]   = timer_two_roll && !wide_mode;
    flag_set[PIF_FL_TIMER1]   = timer_one_roll;
    flag_set[PIF_FL_CAPTURE2] = capture_two_event_i;
    flag_set[PIF_FL_CAPTURE1] = capture_one_event_i;
  end

  // software write first, then hardware set wins
  always_comb
  begin
    request_next = peripheral_request_one_reg;
    if (wr_take && idx == PIF_IDX_REQUEST_ONE && wb_sel_i[0])
      request_next = (peripheral_request_one_reg & ~PIF_FL_WMASK) | (wb_dat_i[7:0] & PIF_FL_WMASK);
    request_next                  = request_next | flag_set;
    request_next[PIF_FL_UART1_TX] = uart_one_tx_empty_i;
    request_next[PIF_FL_UART1_RX] = uart_one_rx_full_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      peripheral_request_one_reg <= PIF_FL_RESET;
    else
      peripheral_request_one_reg <= request_next;
  end

  // second group gated by enable register two
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      second_req_reg <= 8'h00;
    else
      second_req_reg <= second_flags_i & peripheral_enable_two_reg;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_reg <= 1'b0;
    else
      irq_reg <= !global_irq_disable_i && (|(second_flags_i & peripheral_enable_two_reg));
  end

  assign wb_ack_o                 = ack_reg;
  assign wb_dat_o                 = dat_reg;
  assign peripheral_request_one_o = peripheral_request_one_reg;
  assign peripheral_enable_two_o  = peripheral_enable_two_reg;
  assign second_irq_req_o         = second_req_reg;
  assign peripheral_irq_o         = irq_reg;

  // checks
  serial_gate_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 second_irq_req_o[PIF_EN_SERIAL] == ($past(second_flags_i[PIF_EN_SERIAL])
      && $past(peripheral_enable_two_reg[PIF_EN_SERIAL])))
    else $error("serial port request not gated by its enable");

  collision_gate_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (second_flags_i[PIF_EN_COLLISION] && !peripheral_enable_two_reg[PIF_EN_COLLISION])
      |=> !second_irq_req_o[PIF_EN_COLLISION])
    else $error("bus collision request passed while disabled");

  converter_gate_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (second_flags_i[PIF_EN_CONVERTER] && peripheral_enable_two_reg[PIF_EN_CONVERTER])
      |=> second_irq_req_o[PIF_EN_CONVERTER])
    else $error("converter request lost while enabled");

  unused_bit_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    !peripheral_enable_two_reg[PIF_EN_UNUSED] && !second_irq_req_o[PIF_EN_UNUSED])
    else $error("unimplemented enable bit became set");

  capture_gate_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 second_irq_req_o[PIF_EN_CAPTURE4:PIF_EN_CAPTURE3] ==
      ($past(second_flags_i[PIF_EN_CAPTURE4:PIF_EN_CAPTURE3])
      & $past(peripheral_enable_two_reg[PIF_EN_CAPTURE4:PIF_EN_CAPTURE3])))
    else $error("capture three or four request gating wrong");

  uart_tx_gate_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    !peripheral_enable_two_reg[PIF_EN_UART2_TX] |=> !second_irq_req_o[PIF_EN_UART2_TX])
    else $error("uart two transmit request passed while disabled");

  uart_rx_gate_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (second_flags_i[PIF_EN_UART2_RX] && peripheral_enable_two_reg[PIF_EN_UART2_RX])
      |=> second_irq_req_o[PIF_EN_UART2_RX])
    else $error("uart two receive request lost while enabled");

  capture_set_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    capture_one_event_i |=> peripheral_request_one_reg[PIF_FL_CAPTURE1])
    else $error("capture one event did not set its flag");

  timer_one_set_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (!wide_mode && timer_one_period_reg != 8'h00 && timer_one_count_i == timer_one_period_reg
      ##1 timer_one_count_i == 8'h00 && !wide_mode && $stable(timer_one_period_reg))
      |=> peripheral_request_one_reg[PIF_FL_TIMER1])
    else $error("timer one rollover from period did not set its flag");

  overflow_set_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (capture_one_mode && timer_three_count_i == 16'hFFFF
      ##1 capture_one_mode && timer_three_count_i == 16'h0000)
      |=> peripheral_request_one_reg[PIF_FL_TIMER3])
    else $error("timer three overflow did not set its flag");

  timer_three_quiet_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(peripheral_request_one_reg[PIF_FL_TIMER3]) && peripheral_request_one_reg[PIF_FL_TIMER3]
      && !$past(wr_take)) |-> $past(timer_three_count_i == 16'h0000))
    else $error("timer three flag rose without a rollover");

  port_b_hold_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    port_b_mismatch |=> peripheral_request_one_reg[PIF_FL_PORT_B])
    else $error("port b flag clear while mismatch stands");

  ack_pulse_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  global_mask_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    global_irq_disable_i |=> !peripheral_irq_o)
    else $error("peripheral interrupt raised under global disable");

  wide_pair_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (wide_mode && !wr_take && !peripheral_request_one_reg[PIF_FL_TIMER2])
      |=> !peripheral_request_one_reg[PIF_FL_TIMER2])
    else $error("timer two flag set while timers run as a pair");

  enabled_irq_c: cover property (@(posedge clk_i) disable iff (rst_i) peripheral_irq_o);
  port_b_c: cover property (@(posedge clk_i) disable iff (rst_i) flag_set[PIF_FL_PORT_B] && wr_take);
  timer_three_c: cover property (@(posedge clk_i) disable iff (rst_i) timer_three_roll && capture_one_mode);
  flag_write_c: cover property (@(posedge clk_i) disable iff (rst_i) wr_take && idx == PIF_IDX_REQUEST_ONE);
  wide_roll_c: cover property (@(posedge clk_i) disable iff (rst_i) timer_one_roll && wide_mode);
endmodule // pif_core

// ### dv/pif_periph_model.sv
// far-side peripheral model driving the block's event and flag inputs
`timescale 1ns/1ps
module pif_periph_model (
  input  wire logic clk_i,
  output logic [3:0]  port_b_pins_o,
  output logic        cap_one_o,
  output logic        cap_two_o,
  output logic [7:0]  t1_o,
  output logic [7:0]  t2_o,
  output logic [15:0] t3_o,
  output logic        tx_o,
  output logic        rx_o,
  output logic        gdis_o,
  output logic [7:0]  sec_o
);
  initial
  begin
    {port_b_pins_o, cap_one_o, cap_two_o, t1_o, t2_o, t3_o, tx_o, rx_o, gdis_o, sec_o} = '0;
  end
  // single-cycle capture pulse
  task automatic pulse_cap(input bit two);
    @(posedge clk_i);
    if (two) cap_two_o <= 1'b1;
    else cap_one_o <= 1'b1;
    @(posedge clk_i);
    cap_one_o <= 1'b0;
    cap_two_o <= 1'b0;
  endtask
  // count up to the limit, wrap to zero, then stand still
  task automatic roll(input int which, input logic [15:0] lim);
    for (int i = 2; i >= -1; i--)
    begin
      @(posedge clk_i);
      if (which == 1) t1_o <= (i < 0) ? 8'h00 : 8'(lim - 16'(i));
      else if (which == 2) {t2_o, t1_o} <= (i < 0) ? 16'h0000 : lim - 16'(i);
      else t3_o <= (i < 0) ? 16'h0000 : lim - 16'(i);
    end
  endtask
  task automatic set_levels(input logic tx, input logic rx, input logic [7:0] sec, input logic gd);
    @(posedge clk_i);
    tx_o   <= tx;
    rx_o   <= rx;
    sec_o  <= sec;
    gdis_o <= gd;
  endtask
  task automatic set_pins(input logic [3:0] v);
    @(posedge clk_i);
    port_b_pins_o <= v;
  endtask
endmodule // pif_periph_model

// ### dv/pif_core_tb.sv
// self-checking bench for the peripheral enable and request block
`timescale 1ns/1ps
module pif_core_tb;
  import pif_pkg::*;
  typedef struct {logic [7:0] adr; logic [31:0] val;} pif_exp_t;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cap1, cap2, tx, rx, gdis, irq;
  logic [7:0]  wb_adr_i, t1, t2, sec, req_o, en_o, sreq, fl;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] t3;
  logic [3:0]  pins;
  logic [7:0]  en;
  logic [3:0]  wb_sel_i;
  int          error_cnt = 0;
  int          num_checks = 0;
  pif_exp_t    exp_q[$];
  pif_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .port_b_pins_i(pins), .capture_one_event_i(cap1), .capture_two_event_i(cap2),
    .timer_one_count_i(t1), .timer_two_count_i(t2), .timer_three_count_i(t3), .uart_one_tx_empty_i(tx),
    .uart_one_rx_full_i(rx), .global_irq_disable_i(gdis), .second_flags_i(sec),
    .peripheral_request_one_o(req_o), .peripheral_enable_two_o(en_o), .second_irq_req_o(sreq),
    .peripheral_irq_o(irq));
  pif_periph_model u_model (.clk_i(clk_i), .port_b_pins_o(pins), .cap_one_o(cap1), .cap_two_o(cap2),
    .t1_o(t1), .t2_o(t2), .t3_o(t3), .tx_o(tx), .rx_o(rx), .gdis_o(gdis), .sec_o(sec));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) check("ack", 1, 0);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    wb_sel_i <= 4'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back('{a, e});
    xfer(a, 1'b0, 32'h0);
  endtask
  function automatic logic [31:0] req();
    return {24'h0, fl[7:2], tx, rx};
  endfunction
  // read-data monitor against oldest note
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
    begin
      pif_exp_t x;
      x = exp_q.pop_front();
      check($sformatf("read %h", x.adr), x.val, wb_dat_o);
    end
  initial
  begin
    #100000;
    check("watchdog", 0, 1);
    complete_run();
  end
  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} = '0;
    fl = 8'h00;
    rst_i = 1'b1;
    void'($urandom(40917));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    u_model.set_levels(1'($urandom), 1'($urandom), 8'h00, 1'b0);
    repeat (3) @(posedge clk_i);
    rd(8'h44, 32'h0);
    rd(8'h58, req());
    rd(8'h80, 32'h0);
    rd(8'h84, 32'hFFFF);
    rd(8'h88, 32'hFFFF);
    xfer(8'h04, 1'b1, 32'hFF);
    rd(8'h04, 32'h0);
    $display("test reset and unmapped done");
    for (int b = 0; b < 8; b++)
    begin
      xfer(8'h44, 1'b1, 32'h1 << b);
      rd(8'h44, (32'h1 << b) & 32'hEF);
      u_model.set_levels(tx, rx, 8'hFF, 1'b0);
      repeat (3) @(posedge clk_i);
      check("gated", (8'h1 << b) & PIF_EN_WMASK, sreq);
      check("irq", b != 4, irq);
    end
    for (int i = 0; i < 6; i++)
    begin
      en = 8'($urandom);
      u_model.set_levels(tx, rx, 8'($urandom), 1'(i));
      xfer(8'h44, 1'b1, {24'h0, en});
      repeat (3) @(posedge clk_i);
      check("gated rnd", sec & en & PIF_EN_WMASK, sreq);
      check("irq rnd", |(sec & en & PIF_EN_WMASK) && !gdis, irq);
      check("enable out", en & PIF_EN_WMASK, en_o);
    end
    $display("test enable gating done");
    xfer(8'h44, 1'b1, 32'h0);
    u_model.set_levels(tx, rx, 8'h00, 1'b1);
    u_model.pulse_cap(1'b0);
    u_model.pulse_cap(1'b1);
    repeat (2) @(posedge clk_i);
    fl = 8'h0C;
    rd(8'h58, req());
    xfer(8'h58, 1'b1, 32'h0);
    fl = 8'h00;
    rd(8'h58, req());
    $display("test capture flags done");
    xfer(8'h84, 1'b1, 32'h0010);
    u_model.roll(1, 16'h0010);
    repeat (3) @(posedge clk_i);
    fl = 8'h10;
    rd(8'h58, req());
    xfer(8'h88, 1'b1, 32'h0020);
    u_model.roll(3, 16'h0020);
    repeat (3) @(posedge clk_i);
    fl = 8'h50;
    rd(8'h58, req());
    xfer(8'h58, 1'b1, 32'h0);
    xfer(8'h80, 1'b1, 32'h1);
    u_model.roll(3, 16'h0020);
    repeat (3) @(posedge clk_i);
    fl = 8'h00;
    rd(8'h58, req());
    u_model.roll(3, 16'hFFFF);
    repeat (3) @(posedge clk_i);
    fl = 8'h40;
    rd(8'h58, req());
    xfer(8'h58, 1'b1, 32'h0);
    fl = 8'h00;
    xfer(8'h80, 1'b1, 32'h2);
    xfer(8'h84, 1'b1, 32'h0110);
    u_model.roll(2, 16'h0110);
    repeat (3) @(posedge clk_i);
    fl = 8'h10;
    rd(8'h58, req());
    xfer(8'h58, 1'b1, 32'h0);
    fl = 8'h00;
    $display("test timer flags done");
    u_model.set_pins(4'h5);
    repeat (6) @(posedge clk_i);
    xfer(8'h58, 1'b1, 32'h0);
    fl = 8'h80;
    rd(8'h58, req());
    xfer(8'h58, 1'b1, 32'h0);
    fl = 8'h00;
    rd(8'h58, req());
    check("request out", req(), {24'h0, req_o});
    $display("test port b flag done");
    repeat (3) @(posedge clk_i);
    complete_run();
  end
endmodule // pif_core_tb
